//--- design/wfc_cfg.svh
// Purpose: constants of the waveform output control block
// Assumes: 32-bit apb data, one word per register
// Notes:   offsets are byte addresses
`ifndef WFC_CFG_SVH
`define WFC_CFG_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define WFC_OFF_CONTROL   8'h00
`define WFC_OFF_FREQ      8'h04
`define WFC_OFF_STATUS    8'h08

// ****************************************************************
// waveform_control field positions
// ****************************************************************
`define WFC_CTL_W         16
`define WFC_B_RESET       8
`define WFC_B_HALT        7
`define WFC_B_PDOWN       6
`define WFC_B_BITEN       5
`define WFC_B_FULL        3
`define WFC_B_MODE        1
`define WFC_CTL_MASK      16'h01ea
`define WFC_CTL_RST       16'h0000

// ****************************************************************
// datapath sizes and reset values
// ****************************************************************
`define WFC_PH_W          16
`define WFC_DAC_W         10
`define WFC_DAC_MID       10'h200
`define WFC_FREQ_RST      16'h0100
`define WFC_ROM_AW        7
`define WFC_ROM_DEPTH     32

`endif

//--- design/wfc_pkg.sv
// Purpose: shared types of the waveform output control block
// Assumes: constants come from wfc_cfg.svh
// Notes:   one-hot apb states
package wfc_pkg;

    typedef enum logic [1:0] {
        WFC_IDLE   = 2'b01,
        WFC_ACCESS = 2'b10
    } wfc_apb_e;

    typedef logic [9:0] wfc_dac_t;

endpackage : wfc_pkg

//--- design/wfc_sine_rom.sv
// Purpose: quarter-wave sine table with registered output
// Assumes: address is top seven phase bits
// Notes:   output is offset binary around midscale
`include "wfc_cfg.svh"

module wfc_sine_rom
    import wfc_pkg::*;
(
    input  wire logic                      SYS_CLK,
    input  wire logic                      RST_N,
    input  wire logic [`WFC_ROM_AW-1:0]    addr,
    output wfc_dac_t                       data
);

    // ****************************************************************
    // table
    // ****************************************************************
    localparam logic [8:0] TBL [0:`WFC_ROM_DEPTH-1] = '{
        9'h00d, 9'h026, 9'h03f, 9'h057, 9'h070, 9'h088, 9'h0a0, 9'h0b8,
        9'h0cf, 9'h0e6, 9'h0fc, 9'h111, 9'h126, 9'h13a, 9'h14e, 9'h160,
        9'h172, 9'h183, 9'h193, 9'h1a2, 9'h1b0, 9'h1bd, 9'h1c9, 9'h1d3,
        9'h1dd, 9'h1e5, 9'h1ec, 9'h1f2, 9'h1f8, 9'h1fb, 9'h1fe, 9'h1ff
    };

    logic [4:0] idx;
    logic [8:0] mag;
    wfc_dac_t   data_d;
    wfc_dac_t   data_q;

    // ****************************************************************
    // mirror and sign
    // ****************************************************************
    always_comb begin
        idx = addr[5] ? ~addr[4:0] : addr[4:0];
        mag = TBL[idx];
        if (addr[6]) begin
            data_d = `WFC_DAC_MID - {1'b0, mag};
        end else begin
            data_d = `WFC_DAC_MID + {1'b0, mag};
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            data_q <= `WFC_DAC_MID;
        end else begin
            data_q <= data_d;
        end
    end

    assign data = data_q;

endmodule : wfc_sine_rom

//--- design/wfc_top.sv
// Purpose: output path control of a direct digital waveform synthesizer
// Assumes: apb master, one clock, inputs synchronous to SYS_CLK
// Notes:   DAC_DATA lags the phase by two cycles
//
// The implementer's own choices: the APB register port and the register offsets.
`include "wfc_cfg.svh"

module wfc_top
    import wfc_pkg::*;
(
    input  wire logic          SYS_CLK,
    input  wire logic          RST_N,
    input  wire logic          PSEL,
    input  wire logic          PENABLE,
    input  wire logic          PWRITE,
    input  wire logic [7:0]    PADDR,
    input  wire logic [31:0]   PWDATA,
    output logic      [31:0]   PRDATA,
    output logic               PREADY,
    output logic               PSLVERR,
    output wfc_dac_t           DAC_DATA,
    output logic               DAC_POWERDOWN,
    output logic               PIN_SEL_BIT,
    output logic               PIN_BIT
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == `WFC_OFF_CONTROL) || (a == `WFC_OFF_FREQ) || (a == `WFC_OFF_STATUS);
    endfunction : is_mapped

    function automatic wfc_dac_t tri_of(input logic [`WFC_PH_W-1:0] p);
        tri_of = p[15] ? ~p[14:5] : p[14:5];
    endfunction : tri_of

    // ****************************************************************
    // apb slave
    // ****************************************************************
    wfc_apb_e                 st_q;
    wfc_apb_e                 st_d;
    logic [`WFC_CTL_W-1:0]    ctl_q;
    logic [`WFC_CTL_W-1:0]    ctl_d;
    logic [`WFC_PH_W-1:0]     freq_q;
    logic [`WFC_PH_W-1:0]     freq_d;
    logic [31:0]              rdata_q;
    logic [31:0]              rdata_d;
    logic                     err_q;
    logic                     err_d;
    logic                     wr_take;
    logic [`WFC_PH_W-1:0]     phase_q;
    logic                     pin_bit_q;

    always_comb begin
        st_d    = st_q;
        ctl_d   = ctl_q;
        freq_d  = freq_q;
        rdata_d = rdata_q;
        err_d   = err_q;
        wr_take = 1'b0;
        case (st_q)
            WFC_IDLE: begin
                if (PSEL && !PENABLE) begin
                    st_d    = WFC_ACCESS;
                    err_d   = !is_mapped(PADDR);
                    rdata_d = 32'h0000_0000;
                    if (!PWRITE && PADDR == `WFC_OFF_FREQ) begin
                        rdata_d = {16'h0000, freq_q};
                    end else if (!PWRITE && PADDR == `WFC_OFF_STATUS) begin
                        rdata_d = {14'h0000, pin_bit_q, ctl_q[`WFC_B_HALT], phase_q};
                    end
                end
            end
            WFC_ACCESS: begin
                st_d    = WFC_IDLE;
                wr_take = PSEL && PENABLE && PWRITE;
                if (wr_take && PADDR == `WFC_OFF_CONTROL) begin
                    ctl_d = PWDATA[`WFC_CTL_W-1:0] & `WFC_CTL_MASK;
                end
                if (wr_take && PADDR == `WFC_OFF_FREQ) begin
                    freq_d = PWDATA[`WFC_PH_W-1:0];
                end
            end
            default: begin
                st_d = WFC_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_q    <= WFC_IDLE;
            ctl_q   <= `WFC_CTL_RST;
            freq_q  <= `WFC_FREQ_RST;
            rdata_q <= 32'h0000_0000;
            err_q   <= 1'b0;
        end else begin
            st_q    <= st_d;
            ctl_q   <= ctl_d;
            freq_q  <= freq_d;
            rdata_q <= rdata_d;
            err_q   <= err_d;
        end
    end

    assign PREADY  = (st_q == WFC_ACCESS);
    assign PRDATA  = rdata_q;
    assign PSLVERR = PREADY && err_q;

    // ****************************************************************
    // phase accumulator and waveform datapath
    // ****************************************************************
    logic                     f_rst;
    logic                     f_halt;
    logic                     f_biten;
    logic                     f_full;
    logic                     f_mode;
    logic [`WFC_PH_W-1:0]     phase_d;
    wfc_dac_t                 tri_q;
    wfc_dac_t                 tri_d;
    wfc_dac_t                 sine;
    wfc_dac_t                 dac_q;
    wfc_dac_t                 dac_d;
    logic                     div_q;
    logic                     div_d;
    logic                     msb_q;
    logic                     msb_d;
    logic                     sel_q;
    logic                     sel_d;
    logic                     pd_q;
    logic                     pd_d;
    logic                     pin_bit_d;

    assign f_rst   = ctl_q[`WFC_B_RESET];
    assign f_halt  = ctl_q[`WFC_B_HALT];
    assign f_biten = ctl_q[`WFC_B_BITEN];
    assign f_full  = ctl_q[`WFC_B_FULL];
    assign f_mode  = ctl_q[`WFC_B_MODE];

    wfc_sine_rom u_rom (
        .SYS_CLK (SYS_CLK),
        .RST_N   (RST_N),
        .addr    (phase_q[`WFC_PH_W-1 -: `WFC_ROM_AW]),
        .data    (sine)
    );

    always_comb begin
        phase_d   = phase_q;
        tri_d     = tri_of(phase_q);
        dac_d     = dac_q;
        div_d     = div_q;
        msb_d     = msb_q;
        if (f_rst) begin
            phase_d = '0;
            dac_d   = `WFC_DAC_MID;
            div_d   = 1'b0;
            msb_d   = 1'b0;
        end else if (!f_halt) begin
            phase_d = phase_q + freq_q;
            dac_d   = f_mode ? tri_q : sine;
            msb_d   = dac_q[`WFC_DAC_W-1];
            if (dac_q[`WFC_DAC_W-1] && !msb_q) begin
                div_d = !div_q;
            end
        end
        sel_d     = f_biten;
        pin_bit_d = f_full ? dac_q[`WFC_DAC_W-1] : div_q;
        pd_d      = ctl_q[`WFC_B_PDOWN];
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            phase_q   <= '0;
            tri_q     <= '0;
            dac_q     <= `WFC_DAC_MID;
            div_q     <= 1'b0;
            msb_q     <= 1'b0;
            sel_q     <= 1'b0;
            pin_bit_q <= 1'b0;
            pd_q      <= 1'b0;
        end else begin
            phase_q   <= phase_d;
            tri_q     <= tri_d;
            dac_q     <= dac_d;
            div_q     <= div_d;
            msb_q     <= msb_d;
            sel_q     <= sel_d;
            pin_bit_q <= pin_bit_d;
            pd_q      <= pd_d;
        end
    end

    assign DAC_DATA      = dac_q;
    assign DAC_POWERDOWN = pd_q;
    assign PIN_SEL_BIT   = sel_q;
    assign PIN_BIT       = pin_bit_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    a_halt_holds_phase: assert property (f_halt && !f_rst |=> phase_q == $past(phase_q) && dac_q == $past(dac_q))
        else $error("phase or output moved while halted");
    a_run_adds_freq: assert property (!f_halt && !f_rst |=> phase_q == $past(phase_q) + $past(freq_q))
        else $error("accumulator did not add frequency word");
    a_pdown_follows: assert property (DAC_POWERDOWN == $past(ctl_q[`WFC_B_PDOWN]))
        else $error("powerdown not applied");
    a_bit_route_on: assert property (f_biten |=> PIN_SEL_BIT)
        else $error("pin not switched to bit output");
    a_dac_route_on: assert property (!f_biten |=> !PIN_SEL_BIT)
        else $error("pin not connected to converter");
    a_full_msb_out: assert property (f_full |=> PIN_BIT == $past(dac_q[`WFC_DAC_W-1]))
        else $error("pin bit is not converter msb");
    a_tri_wave: assert property ((f_mode && !f_halt && !f_rst) [*3] |-> dac_q == tri_of($past(phase_q, 2)))
        else $error("triangle output wrong");
    a_reset_mid: assert property (f_rst |=> phase_q == '0 && dac_q == `WFC_DAC_MID && !div_q)
        else $error("reset field did not clear state");

    c_bit_half: cover property (f_biten && !f_full && $rose(PIN_BIT));
    c_halt_resume: cover property (f_halt ##1 !f_halt ##1 phase_q != $past(phase_q));
    c_tri_run: cover property ((f_mode && !f_halt) [*4]);
    c_bad_addr: cover property (PSLVERR);

endmodule : wfc_top

//--- dv/tb.sv
// Purpose: self-checking bench of the waveform output control block
// Assumes: apb slave answers in one access cycle
// Notes:   converter and pin outputs sampled at the falling edge, except DAC_DATA in the halt and soft reset tests; PRDATA and PSLVERR at the rising edge
`include "wfc_cfg.svh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin errors++; \
    $display("wrong value %s exp %h got %h", nm, ex, got); end end

module tb
    import wfc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        SYS_CLK = 0, RST_N = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, PRDATA, rd, s1, s2;
    logic        PREADY, PSLVERR, er, DAC_POWERDOWN, PIN_SEL_BIT, PIN_BIT;
    wfc_dac_t    DAC_DATA, dk;
    int          errors = 0, cmp_count = 0, pt, mt, st;

    wfc_top wfc_top_i (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .DAC_DATA(DAC_DATA), .DAC_POWERDOWN(DAC_POWERDOWN),
        .PIN_SEL_BIT(PIN_SEL_BIT), .PIN_BIT(PIN_BIT));

    initial begin
        forever #5 SYS_CLK = ~SYS_CLK;
    end

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic conclude();
        $display("checks %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge SYS_CLK);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge SYS_CLK);
        penable <= 1'b1;
        do begin
            @(posedge SYS_CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        rd = PRDATA;
        er = PSLVERR;
        psel <= 1'b0; penable <= 1'b0;
        if (PREADY !== 1'b1) begin
            errors++;
            conclude();
        end
    endtask : apb

    // toggles of pin and msb, and steps of eight, over 128 cycles
    task automatic measure();
        logic pp, pm;
        wfc_dac_t pd;
        pt = 0; mt = 0; st = 0;
        @(negedge SYS_CLK);
        pp = PIN_BIT; pm = DAC_DATA[9]; pd = DAC_DATA;
        repeat (128) begin
            @(negedge SYS_CLK);
            if (PIN_BIT !== pp) pt++;
            if (DAC_DATA[9] !== pm) mt++;
            if (DAC_DATA - pd == 10'h008 || pd - DAC_DATA == 10'h008) st++;
            pp = PIN_BIT; pm = DAC_DATA[9]; pd = DAC_DATA;
        end
    endtask : measure

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        repeat (4) @(negedge SYS_CLK);
    endtask : wr

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        repeat (2) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        @(negedge SYS_CLK);
        `CHK("dac mid", 10'h200, DAC_DATA)
        `CHK("pdown rst", 1'b0, DAC_POWERDOWN)
        `CHK("pinsel rst", 1'b0, PIN_SEL_BIT)
        apb(1'b0, `WFC_OFF_FREQ, 32'h0);
        `CHK("freq rst", 32'h0000_0100, rd)
        apb(1'b0, `WFC_OFF_CONTROL, 32'h0);
        `CHK("ctl reads 0", 32'h0, rd)
        apb(1'b0, 8'h0c, 32'h0);
        `CHK("unmapped err", 1'b1, er)
        $display("test reset done");

        apb(1'b0, `WFC_OFF_STATUS, 32'h0); s1 = rd;
        apb(1'b0, `WFC_OFF_STATUS, 32'h0); s2 = rd;
        `CHK("phase step", 16'h0300, 16'(s2[15:0] - s1[15:0]))
        wr(`WFC_OFF_CONTROL, 32'h0080);
        apb(1'b0, `WFC_OFF_STATUS, 32'h0); s1 = rd;
        dk = DAC_DATA;
        apb(1'b0, `WFC_OFF_STATUS, 32'h0); s2 = rd;
        `CHK("halt flag", 1'b1, s1[16])
        `CHK("halt phase", s1[15:0], s2[15:0])
        `CHK("halt dac", dk, DAC_DATA)
        wr(`WFC_OFF_FREQ, 32'h1);
        wr(`WFC_OFF_CONTROL, 32'h0);
        apb(1'b0, `WFC_OFF_STATUS, 32'h0); s2 = rd;
        `CHK("resume", 16'h0004, 16'(s2[15:0] - s1[15:0]))
        $display("test halt done");

        wr(`WFC_OFF_CONTROL, 32'h0040);
        `CHK("pdown set", 1'b1, DAC_POWERDOWN)
        wr(`WFC_OFF_CONTROL, 32'h0);
        `CHK("pdown clr", 1'b0, DAC_POWERDOWN)
        wr(`WFC_OFF_CONTROL, 32'h0214);
        `CHK("resv pdown", 1'b0, DAC_POWERDOWN)
        `CHK("resv pinsel", 1'b0, PIN_SEL_BIT)
        $display("test powerdown done");

        wr(`WFC_OFF_FREQ, 32'h0100);
        wr(`WFC_OFF_CONTROL, 32'h0100);
        apb(1'b0, `WFC_OFF_STATUS, 32'h0);
        `CHK("sreset phase", 16'h0, rd[15:0])
        `CHK("sreset dac", 10'h200, DAC_DATA)
        wr(`WFC_OFF_CONTROL, 32'h0);
        apb(1'b0, `WFC_OFF_STATUS, 32'h0);
        `CHK("sreset off", 16'h0400, rd[15:0])
        $display("test soft reset done");

        wr(`WFC_OFF_FREQ, 32'h1000);
        wr(`WFC_OFF_CONTROL, 32'h0028);
        measure();
        `CHK("pinsel bit", 1'b1, PIN_SEL_BIT)
        `CHK("msb toggles", 32'h0000_0010, mt)
        `CHK("full toggles", 32'h0000_0010, pt)
        wr(`WFC_OFF_CONTROL, 32'h0020);
        measure();
        `CHK("half toggles", 32'h0000_0008, pt)
        $display("test bit output done");

        wr(`WFC_OFF_FREQ, 32'h0100);
        wr(`WFC_OFF_CONTROL, 32'h0002);
        measure();
        `CHK("pinsel dac", 1'b0, PIN_SEL_BIT)
        `CHK("tri steps", 1'b1, st >= 120)
        wr(`WFC_OFF_CONTROL, 32'h0);
        measure();
        `CHK("sine steps", 1'b1, st < 64)
        $display("test waveform done");
        conclude();
    end
endmodule : tb
